// >>> hw/pulse_output_generator.sv
// pulse output generator: fast pairs, slow channels, rail-enable pin drive, apb registers
//
// Functional notes
// - fast period = source divided by integer 2 .. 2^14-1
// - fast duty steps in sixteenths of a source period
// - fast channels paired 1-2, 3-4, 5-6, 7-8 sharing one period
// - setting one fast pin to pulse enables an unassigned companion too
// - within a pair one pin may pulse while the other is general output
// - unused fast pins may be general outputs, driven low from reset
// - during reset plain pins float, fast pins are driven low
// - slow period = slow source divided by integer 2 .. 2^24-1
// - slow duty steps in whole slow source periods
// - slow outputs below 238 Hz get 0.0015 percent duty steps
// - each slow pin is a general input or a pulse output
// - each fast channel has a phase offset from 0 to 360 degrees
// - any fast or plain pin (not a slow pin) can be a rail enable, either polarity, open-drain or push-pull
// - at most ten pins are rail enables at once
`default_nettype none

module pulse_output_generator
  import pulse_gen_pkg::*;
(
  input  wire  logic                          clock,         // 100 mhz system clock
  input  wire  logic                          rst,           // synchronous reset
  input  wire  logic                          psel,          // apb select
  input  wire  logic                          penable,       // apb access phase
  input  wire  logic                          pwrite,        // apb write
  input  wire  logic [7:0]                    paddr,         // apb byte address
  input  wire  logic [31:0]                   pwdata,        // apb write data
  output logic       [31:0]                   prdata,        // apb read data
  output logic                                pready,        // apb ready
  output logic                                pslverr,       // apb error
  input  wire  logic [pulse_gen_pkg::PINS-1:0]    pin_in,    // general pin levels
  output logic       [pulse_gen_pkg::PINS-1:0]    pin_out,   // general pin drive value
  output logic       [pulse_gen_pkg::PINS-1:0]    pin_oe,    // general pin drive enable
  input  wire  logic [pulse_gen_pkg::SLOW_CH-1:0] slow_in,   // slow pin levels
  output logic       [pulse_gen_pkg::SLOW_CH-1:0] slow_out,  // slow pin drive value
  output logic       [pulse_gen_pkg::SLOW_CH-1:0] slow_oe    // slow pin drive enable
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0]              fast_mode_r;
  logic [SLOW_CH-1:0]       slow_mode_r;
  logic [PINS-1:0]          out_val_r;
  logic [PINS-1:0]          rail_sel_r;
  logic [PINS-1:0]          rail_low_r;
  logic [PINS-1:0]          rail_od_r;
  logic [PLAIN_PINS-1:0]    gen_dir_r;
  logic [FAST_DIV_W-1:0]    pair_period_r [PAIRS];
  logic [FAST_DUTY_W-1:0]   fast_duty_r   [FAST_CH];
  logic [FAST_DIV_W-1:0]    fast_phase_r  [FAST_CH];
  logic [SLOW_DIV_W-1:0]    slow_period_r [SLOW_CH];
  logic [SLOW_DIV_W-1:0]    slow_duty_r   [SLOW_CH];
  logic [FAST_DIV_W-1:0]    pair_cnt_r    [PAIRS];
  logic [SUB_W-1:0]         pair_sub_r    [PAIRS];
  logic [SLOW_DIV_W-1:0]    slow_cnt_r    [SLOW_CH];
  logic [3:0]               tick_cnt_r;
  logic                     slow_tick;
  logic [FAST_CH-1:0]       fast_wave;
  logic [SLOW_CH-1:0]       slow_wave;
  logic [PINS-1:0]          pin_out_nxt;
  logic [PINS-1:0]          pin_oe_nxt;
  logic [15:0]              fast_mode_nxt;
  logic [31:0]              rdata_nxt;
  logic                     unmapped;
  logic                     wr_en;
  logic                     setup;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // word index inside a block of registers, or -1 when outside it
  function automatic int block_index(input logic [7:0] addr, input logic [7:0] base,
                                     input int count);
    int idx;
    idx = (int'(addr) - int'(base)) / 4;
    if (addr < base || idx >= count || addr[1:0] != 2'h0)
      return -1;
    return idx;
  endfunction : block_index

  function automatic logic [4:0] count_ones(input logic [PINS-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < PINS; k++)
      n = n + {4'h0, v[k]};
    return n;
  endfunction : count_ones

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // read data is fetched in the setup cycle so it stands in a flop at access
  always_comb begin
    int i;
    rdata_nxt = 32'h0;
    unmapped  = 1'b0;
    i         = 0;
    case (paddr)
      REG_FAST_MODE:  rdata_nxt = {16'h0, fast_mode_r};
      REG_SLOW_MODE:  rdata_nxt = {30'h0, slow_mode_r};
      REG_OUT_VAL:    rdata_nxt = {11'h0, out_val_r};
      REG_RAIL_SEL:   rdata_nxt = {11'h0, rail_sel_r};
      REG_RAIL_LOW:   rdata_nxt = {11'h0, rail_low_r};
      REG_RAIL_OD:    rdata_nxt = {11'h0, rail_od_r};
      REG_GEN_DIR:    rdata_nxt = {19'h0, gen_dir_r};
      REG_PIN_IN:     rdata_nxt = {9'h0, slow_in, pin_in};
      REG_RAIL_COUNT: rdata_nxt = {27'h0, count_ones(rail_sel_r)};
      default: begin
        unmapped = 1'b1;
        i = block_index(paddr, REG_PAIR_PERIOD, PAIRS);
        if (i >= 0) begin
          rdata_nxt = {18'h0, pair_period_r[i]};
          unmapped  = 1'b0;
        end
        i = block_index(paddr, REG_FAST_DUTY, FAST_CH);
        if (i >= 0) begin
          rdata_nxt = {14'h0, fast_duty_r[i]};
          unmapped  = 1'b0;
        end
        i = block_index(paddr, REG_FAST_PHASE, FAST_CH);
        if (i >= 0) begin
          rdata_nxt = {18'h0, fast_phase_r[i]};
          unmapped  = 1'b0;
        end
        i = block_index(paddr, REG_SLOW_PERIOD, SLOW_CH);
        if (i >= 0) begin
          rdata_nxt = {8'h0, slow_period_r[i]};
          unmapped  = 1'b0;
        end
        i = block_index(paddr, REG_SLOW_DUTY, SLOW_CH);
        if (i >= 0) begin
          rdata_nxt = {8'h0, slow_duty_r[i]};
          unmapped  = 1'b0;
        end
      end
    endcase
  end

  // zero wait states; error flag and data settle in the setup cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= pwrite ? 32'h0 : rdata_nxt;
        pslverr <= unmapped;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin function registers
  // ---------------------------------------------------------------
  // a companion left unassigned follows its partner into pulse mode
  always_comb begin
    fast_mode_nxt = pwdata[15:0];
    for (int p = 0; p < PAIRS; p++) begin
      if (pwdata[4*p +: 2] == FN_PULSE && pwdata[4*p+2 +: 2] == FN_UNUSED)
        fast_mode_nxt[4*p+2 +: 2] = FN_PULSE;
      if (pwdata[4*p+2 +: 2] == FN_PULSE && pwdata[4*p +: 2] == FN_UNUSED)
        fast_mode_nxt[4*p +: 2] = FN_PULSE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fast_mode_r <= FAST_MODE_RST;
      slow_mode_r <= SLOW_MODE_RST;
      out_val_r   <= '0;
      gen_dir_r   <= '0;
    end else if (wr_en) begin
      case (paddr)
        REG_FAST_MODE: fast_mode_r <= fast_mode_nxt;
        REG_SLOW_MODE: slow_mode_r <= pwdata[SLOW_CH-1:0];
        REG_OUT_VAL:   out_val_r   <= pwdata[PINS-1:0];
        REG_GEN_DIR:   gen_dir_r   <= pwdata[PLAIN_PINS-1:0];
        default:       fast_mode_r <= fast_mode_r;
      endcase
    end
  end

  // a selection naming more than the allowed number of rails is refused
  always_ff @(posedge clock) begin
    if (rst) begin
      rail_sel_r <= '0;
      rail_low_r <= '0;
      rail_od_r  <= '0;
    end else if (wr_en) begin
      if (paddr == REG_RAIL_SEL && count_ones(pwdata[PINS-1:0]) <= 5'(RAIL_MAX))
        rail_sel_r <= pwdata[PINS-1:0];
      if (paddr == REG_RAIL_LOW)
        rail_low_r <= pwdata[PINS-1:0];
      if (paddr == REG_RAIL_OD)
        rail_od_r <= pwdata[PINS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // timing registers; divisors below the minimum are raised to it
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int p = 0; p < PAIRS; p++)
        pair_period_r[p] <= FAST_DIV_MIN;
      for (int c = 0; c < FAST_CH; c++) begin
        fast_duty_r[c]  <= '0;
        fast_phase_r[c] <= '0;
      end
    end else if (wr_en) begin
      for (int p = 0; p < PAIRS; p++)
        if (block_index(paddr, REG_PAIR_PERIOD, PAIRS) == p)
          pair_period_r[p] <= (pwdata[FAST_DIV_W-1:0] < FAST_DIV_MIN) ?
                              FAST_DIV_MIN : pwdata[FAST_DIV_W-1:0];
      for (int c = 0; c < FAST_CH; c++) begin
        if (block_index(paddr, REG_FAST_DUTY, FAST_CH) == c)
          fast_duty_r[c] <= pwdata[FAST_DUTY_W-1:0];
        if (block_index(paddr, REG_FAST_PHASE, FAST_CH) == c)
          fast_phase_r[c] <= pwdata[FAST_DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int s = 0; s < SLOW_CH; s++) begin
        slow_period_r[s] <= SLOW_DIV_MIN;
        slow_duty_r[s]   <= '0;
      end
    end else if (wr_en) begin
      for (int s = 0; s < SLOW_CH; s++) begin
        if (block_index(paddr, REG_SLOW_PERIOD, SLOW_CH) == s)
          slow_period_r[s] <= (pwdata[SLOW_DIV_W-1:0] < SLOW_DIV_MIN) ?
                              SLOW_DIV_MIN : pwdata[SLOW_DIV_W-1:0];
        if (block_index(paddr, REG_SLOW_DUTY, SLOW_CH) == s)
          slow_duty_r[s] <= pwdata[SLOW_DIV_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // fast pairs: one counter per pair; each source tick is one clock
  // ---------------------------------------------------------------
  // the sub-step counter advances once per period, dithering the edge
  // over sixteen periods since the clock cannot place it mid-cycle
  generate
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      always_ff @(posedge clock) begin
        if (rst) begin
          pair_cnt_r[p] <= '0;
          pair_sub_r[p] <= '0;
        end else if (pair_cnt_r[p] >= pair_period_r[p] - 14'h0001) begin
          pair_cnt_r[p] <= '0;
          pair_sub_r[p] <= pair_sub_r[p] + 4'h1;
        end else begin
          pair_cnt_r[p] <= pair_cnt_r[p] + 14'h0001;
        end
      end
    end

    for (genvar c = 0; c < FAST_CH; c++) begin : g_fast
      logic [FAST_DIV_W:0]    sum;
      logic [FAST_DIV_W-1:0]  shifted;
      logic [FAST_DUTY_W:0]   fine;
      // a phase beyond the period wraps only once; software keeps it below
      assign sum     = {1'b0, pair_cnt_r[c/2]} + {1'b0, fast_phase_r[c]};
      assign shifted = (sum >= {1'b0, pair_period_r[c/2]}) ?
                       FAST_DIV_W'(sum - {1'b0, pair_period_r[c/2]}) :
                       sum[FAST_DIV_W-1:0];
      assign fine    = {1'b0, shifted, pair_sub_r[c/2]};
      assign fast_wave[c] = fine < {1'b0, fast_duty_r[c]};
    end
  endgenerate

  // ---------------------------------------------------------------
  // slow channels, driven by the slow source tick enable
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst)
      tick_cnt_r <= '0;
    else if (tick_cnt_r == 4'(SLOW_TICK_DIV - 1))
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 4'h1;
  end

  assign slow_tick = (tick_cnt_r == 4'(SLOW_TICK_DIV - 1));

  generate
    for (genvar s = 0; s < SLOW_CH; s++) begin : g_slow
      always_ff @(posedge clock) begin
        if (rst)
          slow_cnt_r[s] <= '0;
        else if (slow_tick && slow_cnt_r[s] >= slow_period_r[s] - 24'h000001)
          slow_cnt_r[s] <= '0;
        else if (slow_tick)
          slow_cnt_r[s] <= slow_cnt_r[s] + 24'h000001;
      end
      // whole-period steps: long periods give fine steps on their own
      assign slow_wave[s] = slow_cnt_r[s] < slow_duty_r[s];
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_comb begin
    logic drive;
    drive       = 1'b0;
    pin_out_nxt = '0;
    pin_oe_nxt  = '0;
    for (int k = 0; k < PINS; k++) begin
      drive = rail_low_r[k] ? ~out_val_r[k] : out_val_r[k];
      if (k < FAST_CH && fast_mode_r[2*k +: 2] == FN_PULSE) begin
        pin_out_nxt[k] = fast_wave[k];
        pin_oe_nxt[k]  = 1'b1;
      end else if (rail_sel_r[k]) begin
        pin_out_nxt[k] = rail_od_r[k] ? 1'b0 : drive;
        pin_oe_nxt[k]  = rail_od_r[k] ? ~drive : 1'b1;
      end else if (k < FAST_CH) begin
        // unused and general fast pins are always driven
        pin_out_nxt[k] = (fast_mode_r[2*k +: 2] == FN_GENERAL) && out_val_r[k];
        pin_oe_nxt[k]  = 1'b1;
      end else begin
        pin_out_nxt[k] = out_val_r[k];
        pin_oe_nxt[k]  = gen_dir_r[k - FAST_CH];
      end
    end
  end

  // registered pins: fast pins low and driven, others released in reset
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe  <= {{PLAIN_PINS{1'b0}}, {FAST_CH{1'b1}}};
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe  <= pin_oe_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      slow_out <= '0;
      slow_oe  <= '0;
    end else begin
      slow_out <= slow_wave & slow_mode_r;
      slow_oe  <= slow_mode_r;
    end
  end

endmodule : pulse_output_generator

`default_nettype wire

// >>> common/pulse_gen_pkg.sv
// constants, register map and types shared by the pulse output generator
`default_nettype none

package pulse_gen_pkg;

  // ---------------------------------------------------------------
  // clocking and source rates
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ        = 100;
  localparam int FAST_SRC_KHZ     = 250000;
  localparam int SLOW_SRC_KHZ     = 15625;
  localparam int SLOW_TICK_DIV    = FAST_SRC_KHZ / SLOW_SRC_KHZ;   // 16

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int FAST_CH          = 8;
  localparam int PAIRS            = 4;
  localparam int PLAIN_PINS       = 13;
  localparam int PINS             = FAST_CH + PLAIN_PINS;          // 21
  localparam int SLOW_CH          = 2;
  localparam int FAST_DIV_W       = 14;
  localparam int SUB_W            = 4;
  localparam int FAST_DUTY_W      = FAST_DIV_W + SUB_W;
  localparam int SLOW_DIV_W       = 24;
  localparam int RAIL_MAX         = 10;

  localparam logic [FAST_DIV_W-1:0] FAST_DIV_MIN = 14'h0002;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_MIN = 24'h000002;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_FAST_MODE   = 8'h00;
  localparam logic [7:0] REG_SLOW_MODE   = 8'h04;
  localparam logic [7:0] REG_OUT_VAL     = 8'h08;
  localparam logic [7:0] REG_RAIL_SEL    = 8'h0c;
  localparam logic [7:0] REG_RAIL_LOW    = 8'h10;
  localparam logic [7:0] REG_RAIL_OD     = 8'h14;
  localparam logic [7:0] REG_GEN_DIR     = 8'h18;
  localparam logic [7:0] REG_PIN_IN      = 8'h1c;
  localparam logic [7:0] REG_RAIL_COUNT  = 8'h20;
  localparam logic [7:0] REG_PAIR_PERIOD = 8'h30;   // 4 words
  localparam logic [7:0] REG_FAST_DUTY   = 8'h40;   // 8 words
  localparam logic [7:0] REG_FAST_PHASE  = 8'h60;   // 8 words
  localparam logic [7:0] REG_SLOW_PERIOD = 8'h80;   // 2 words
  localparam logic [7:0] REG_SLOW_DUTY   = 8'h88;   // 2 words

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] FAST_MODE_RST = 16'h0000;
  localparam logic [1:0]  SLOW_MODE_RST = 2'h0;

  // function of a fast channel pin
  typedef enum logic [1:0] {
    FN_UNUSED,
    FN_PULSE,
    FN_GENERAL,
    FN_RESERVED
  } fast_fn_type;

endpackage : pulse_gen_pkg

`default_nettype wire

// >>> bench/pulse_output_generator_sva.sv
// assertion checker for the pulse output generator ports
`default_nettype none

module pulse_gen_checker
  import pulse_gen_pkg::*;
(
  input wire logic                                clock,    // system clock
  input wire logic                                rst,      // synchronous reset
  input wire logic                                psel,     // apb select
  input wire logic                                penable,  // apb access phase
  input wire logic                                pwrite,   // apb write
  input wire logic [7:0]                          paddr,    // apb address
  input wire logic [31:0]                         prdata,   // apb read data
  input wire logic                                pready,   // apb ready
  input wire logic                                pslverr,  // apb error
  input wire logic [pulse_gen_pkg::PINS-1:0]      pin_in,   // pin levels
  input wire logic [pulse_gen_pkg::PINS-1:0]      pin_out,  // pin drive value
  input wire logic [pulse_gen_pkg::PINS-1:0]      pin_oe,   // pin drive enable
  input wire logic [pulse_gen_pkg::SLOW_CH-1:0]   slow_in,  // slow pin levels
  input wire logic [pulse_gen_pkg::SLOW_CH-1:0]   slow_oe   // slow pin enable
);
  timeunit 1ns;
  timeprecision 1ps;

  // reset-time pin states are checked while reset is high, so no disable there
  property p_rst_fast_low;
    @(posedge clock) rst |=> (pin_oe[7:0] == 8'hff) && (pin_out[7:0] == 8'h00);
  endproperty
  a_rst_fast_low: assert property (p_rst_fast_low) else $error("fast pins not low in reset");
  property p_rst_plain_float;
    @(posedge clock) rst |=> pin_oe[PINS-1:FAST_CH] == '0;
  endproperty
  a_rst_plain_float: assert property (p_rst_plain_float) else $error("plain pin driven in reset");
  property p_rst_slow_float;
    @(posedge clock) rst |=> slow_oe == 2'h0;
  endproperty
  a_rst_slow_float: assert property (p_rst_slow_float) else $error("slow pin driven in reset");
  property p_release_fast_low;
    @(posedge clock) disable iff (rst) $past(rst) |-> pin_oe[7:0] == 8'hff && pin_out[7:0] == 8'h00;
  endproperty
  a_release_fast_low: assert property (p_release_fast_low) else $error("fast pins not low after reset");
  property p_ready_rst;
    @(posedge clock) rst |=> !pready;
  endproperty
  a_ready_rst: assert property (p_ready_rst) else $error("ready during reset");
  property p_ready_run;
    @(posedge clock) disable iff (rst) !$past(rst) |-> pready;
  endproperty
  a_ready_run: assert property (p_ready_run) else $error("ready dropped");
  property p_misaligned_err;
    @(posedge clock) disable iff (rst) psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  a_misaligned_err: assert property (p_misaligned_err) else $error("misaligned access not refused");
  property p_write_zero;
    @(posedge clock) disable iff (rst) psel && !penable && pwrite |=> prdata == 32'h0;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("read data not zero on write");
  // pin levels register at the setup edge, so the read sees the levels of that edge
  property p_pin_read;
    @(posedge clock) disable iff (rst) psel && !penable && !pwrite && paddr == REG_PIN_IN
      |=> prdata == {9'h0, $past(slow_in), $past(pin_in)};
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");
  // a refused selection must leave the rail count at or below the limit
  property p_rail_limit;
    @(posedge clock) disable iff (rst) psel && !penable && !pwrite && paddr == REG_RAIL_COUNT
      |=> prdata <= 32'(RAIL_MAX);
  endproperty
  a_rail_limit: assert property (p_rail_limit) else $error("rail count above limit");
endmodule : pulse_gen_checker

bind pulse_output_generator pulse_gen_checker u_chk (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .slow_in(slow_in), .slow_oe(slow_oe));

`default_nettype wire

// >>> bench/pin_far_side.sv
// far-side model: supply enables with pull resistors, slow pins driven by a source
`default_nettype none

module pin_far_side
  import pulse_gen_pkg::*;
(
  input  wire logic [pulse_gen_pkg::PINS-1:0]    pin_out,    // device drive value
  input  wire logic [pulse_gen_pkg::PINS-1:0]    pin_oe,     // device drive enable
  input  wire logic [pulse_gen_pkg::SLOW_CH-1:0] slow_out,   // slow drive value
  input  wire logic [pulse_gen_pkg::SLOW_CH-1:0] slow_oe,    // slow drive enable
  input  wire logic [pulse_gen_pkg::SLOW_CH-1:0] slow_drive, // external slow source
  output logic      [pulse_gen_pkg::PINS-1:0]    pin_level,  // resolved pin wires
  output logic      [pulse_gen_pkg::SLOW_CH-1:0] slow_level  // resolved slow wires
);
  timeunit 1ns;
  timeprecision 1ps;

  // fast pins pulled down, plain pins pulled up, so released lines hold supplies off
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : (i >= FAST_CH);
    end
    for (int s = 0; s < SLOW_CH; s++) begin
      slow_level[s] = slow_oe[s] ? slow_out[s] : slow_drive[s];
    end
  end
endmodule : pin_far_side

`default_nettype wire

// >>> bench/pulse_output_generator_bench.sv
// self-checking bench for the pulse output generator
`default_nettype none

module pulse_output_generator_bench;
  import pulse_gen_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata;
  logic              pready, pslverr;
  logic [PINS-1:0]   pin_lvl, pin_out, pin_oe;
  logic [1:0]        slow_lvl, slow_out, slow_oe;
  logic [1:0]        slow_drive = 2'h1;
  logic [32:0]       expq[$];
  int                miscompares = 0;
  int                compares = 0;

  always #5 clock = ~clock;

  pulse_output_generator dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .slow_in(slow_lvl), .slow_out(slow_out), .slow_oe(slow_oe));
  pin_far_side far (.pin_out(pin_out), .pin_oe(pin_oe), .slow_out(slow_out),
    .slow_oe(slow_oe), .slow_drive(slow_drive), .pin_level(pin_lvl), .slow_level(slow_lvl));

  task results;
    // a read whose answer was never compared is a mismatch too
    if (expq.size() != 0) miscompares++;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // expected {pslverr, prdata} is queued; the monitor compares it
  task rd(input logic [7:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // counts cycles where wire a (and wire b when b >= 0) is high; window is whole periods
  task meas(input int a, input int b, input int n, input int exp);
    int cnt;
    logic [22:0] v;
    cnt = 0;
    repeat (40) @(posedge clock);
    repeat (n) begin
      @(posedge clock);
      v = {slow_lvl, pin_lvl};
      if (v[a] === 1'b1 && (b < 0 || v[b] === 1'b1)) cnt++;
    end
    chk(33'(cnt), 33'(exp));
  endtask : meas

  // read completions are taken at the access edge
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end

  initial begin
    logic [31:0] v;
    void'($urandom(32'h9c7a04d6));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(REG_FAST_MODE, 33'h0);
    rd(REG_SLOW_MODE, 33'h0);
    for (int p = 0; p < PAIRS; p++) rd(REG_PAIR_PERIOD + 8'(4 * p), 33'h2);
    for (int s = 0; s < SLOW_CH; s++) rd(REG_SLOW_PERIOD + 8'(4 * s), 33'h2);
    rd(8'h24, {1'b1, 32'h0});
    rd(8'h01, {1'b1, 32'h0});
    rd(REG_PIN_IN, {10'h0, slow_drive, 13'h1fff, 8'h00});
    wr(REG_PAIR_PERIOD, 32'h0);
    rd(REG_PAIR_PERIOD, 33'h2);
    wr(REG_PAIR_PERIOD, 32'h3fff);
    rd(REG_PAIR_PERIOD, 33'h3fff);
    wr(REG_SLOW_PERIOD, 32'h1);
    rd(REG_SLOW_PERIOD, 33'h2);
    wr(REG_SLOW_PERIOD, 32'hffffff);
    rd(REG_SLOW_PERIOD, 33'hffffff);
    // pair 0 at period 5: 2.5 and 3 clocks high, companion enabled by the pulse write
    wr(REG_PAIR_PERIOD, 32'h5);
    wr(REG_FAST_DUTY, 32'h28);
    wr(REG_FAST_DUTY + 8'h4, 32'h30);
    wr(REG_FAST_MODE, 32'h1);
    rd(REG_FAST_MODE, 33'h5);
    meas(0, -1, 80, 40);
    meas(1, -1, 80, 48);
    // equal duty, companion shifted by 2 clocks: the high phases never overlap
    wr(REG_FAST_DUTY, 32'h20);
    wr(REG_FAST_DUTY + 8'h4, 32'h20);
    wr(REG_FAST_PHASE + 8'h4, 32'h2);
    meas(0, 1, 80, 0);
    wr(REG_FAST_PHASE + 8'h4, 32'h0);
    meas(0, 1, 80, 32);
    wr(REG_OUT_VAL, 32'h2);
    wr(REG_FAST_MODE, 32'h9);
    meas(1, -1, 80, 80);
    meas(0, -1, 80, 32);
    // slow channel: period 3 ticks of 16 clocks, one tick high
    wr(REG_SLOW_PERIOD, 32'h3);
    wr(REG_SLOW_DUTY, 32'h1);
    wr(REG_SLOW_DUTY + 8'h4, 32'h2);
    wr(REG_SLOW_MODE, 32'h3);
    meas(21, -1, 96, 32);
    meas(22, -1, 96, 96);
    // rail enables: push-pull high, push-pull active low, open-drain released and pulled
    wr(REG_FAST_MODE, 32'h0);
    wr(REG_SLOW_MODE, 32'h0);
    wr(REG_OUT_VAL, 32'h700);
    wr(REG_RAIL_LOW, 32'h200);
    wr(REG_RAIL_OD, 32'hc00);
    wr(REG_RAIL_SEL, 32'hf00);
    rd(REG_PIN_IN, {10'h0, slow_drive, 13'h1ff5, 8'h00});
    rd(REG_RAIL_COUNT, 33'h4);
    wr(REG_RAIL_SEL, 32'h7ff00);
    rd(REG_RAIL_SEL, 33'hf00);
    rd(REG_RAIL_COUNT, 33'h4);
    wr(REG_RAIL_SEL, 32'h3ff00);
    rd(REG_RAIL_COUNT, 33'ha);
    // random general output values on every pin, random slow input levels
    wr(REG_RAIL_SEL, 32'h0);
    wr(REG_GEN_DIR, 32'h1fff);
    wr(REG_FAST_MODE, 32'haaaa);
    repeat (4) begin
      v = $urandom;
      slow_drive <= 2'($urandom);
      wr(REG_OUT_VAL, v);
      repeat (3) @(posedge clock);
      rd(REG_PIN_IN, {10'h0, slow_drive, v[20:0]});
    end
    // second reset in mid-run: fast pins pulled low by the device, plain pins released
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    chk(33'(pin_lvl), 33'h1fff00);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd(REG_OUT_VAL, 33'h0);
    // let the monitor take the last read before the verdict
    repeat (2) @(posedge clock);
    results();
  end
endmodule : pulse_output_generator_bench

`default_nettype wire
